/* File: src/digipot_spi_shutdown_reset_ctrl.sv */
// Control logic of a dual 256-step digital potentiometer behind a serial port.
// Assumes an external master drives csN, spiClk and spiDin; the remaining pins
// come from board logic asynchronous to mclk.
//
// How it works
// - Command bits 5:4 select nop (00/11), write (01) or shutdown (10).
// - Input sampled on rising serial clock, output changed on falling edge.
// - Write loads the data byte into each pot whose select bit is one.
// - Command 1,0 is software shutdown of the selected pots.
// - Each selected pot enters shutdown alone; unselected pots stay unchanged.
// - Valid write with power-save high updates and leaves shutdown at frame end.
// - Valid write with power-save low updates but shutdown persists.
// - Invalid or aborted frames change no data or shutdown state, but still arm release by preset or power-save.
// - After a frame, preset low 150 ns sets mid-scale, releases shutdown if awake.
// - After a frame, power-save rising after 100 ns low releases shutdown.
// - Power-save low forces every pot into shutdown.
// - Hardware shutdown keeps data registers; pots resume them on release.
// - Shifting and serial output continue while power-save is low.
// - Serial output is the last stage of the 16-bit shift register.
// - Serial output is push-pull, goes low at the third core clock edge after chip select rises.
// - Shift register is cleared after each frame, so first 16 bits out are zero.
// - Frames whose clock count is not a multiple of 16 are aborted.
// - Preset low 150 ns with chip select high sets all registers to 80h.
// - Preset during power-save low sets mid-scale; shutdown stays until release.
// - Power-on sets registers to 80h and clears software shutdown.
// - Power-up with power-save low starts shut down at mid-scale.
// - Chip select falling starts a frame and leaves standby.
`timescale 1ns/1ps
`default_nettype none
`include "digipot_params.svh"

module digipot_spi_shutdown_reset_ctrl (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  spiClk,
   input  wire logic                  csN,
   input  wire logic                  spiDin,
   output var  logic                  spiDout,
   input  wire logic                  wiperPresetN,
   input  wire logic                  powerSavePinN,
   output var  logic [`DP_DATA_W-1:0] wiper0,
   output var  logic [`DP_DATA_W-1:0] wiper1,
   output var  logic [1:0]            potShutdown,
   output var  logic                  standby
);

   localparam logic [`DP_TIMER_W-1:0] RS_CYC = `DP_TIMER_W'(`DP_PRESET_CYC);
   localparam logic [`DP_TIMER_W-1:0] PS_CYC = `DP_TIMER_W'(`DP_PSAVE_CYC);
   localparam int CMD_HI = `DP_DATA_W + `DP_CMD_HI_POS;
   localparam int CMD_LO = `DP_DATA_W + `DP_CMD_LO_POS;
   localparam int SEL1   = `DP_DATA_W + `DP_SEL1_POS;
   localparam int SEL0   = `DP_DATA_W + `DP_SEL0_POS;

   digipot_pkg::link_s lk_r;
   digipot_pkg::link_s lk_nxt;
   digipot_pkg::core_s c_r;
   digipot_pkg::core_s c_nxt;
   logic               so_r;

   logic                  csRise;
   logic                  frameOk;
   logic                  execCmd;
   digipot_pkg::cmd_e     cmd;
   logic [1:0]            sel;
   logic [`DP_DATA_W-1:0] data;
   logic                  presetFire;
   logic                  psRise;

   // ==========================================================
   // Link side: shift register and clock count
   // ==========================================================
   // The core clears this side with a pulse that starts high under rst,
   // so the serial clock is never needed outside a frame.
   always_comb begin
      lk_nxt = lk_r;
      if (!csN) begin
         lk_nxt.sr  = {lk_r.sr[`DP_FRAME_BITS-2:0], spiDin};
         lk_nxt.cnt = `DP_CNT_W'(lk_r.cnt + 1'b1);
      end
   end

   always_ff @(posedge spiClk or posedge c_r.clr) begin
      if (c_r.clr) begin
         lk_r <= '0;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   // Last stage drives the pin, updated on the falling edge
   always_ff @(negedge spiClk or posedge c_r.clr) begin
      if (c_r.clr) begin
         so_r <= 1'b0;
      end else if (!csN) begin
         so_r <= lk_r.sr[`DP_FRAME_BITS-1];
      end
   end

   assign spiDout = so_r;

   // ==========================================================
   // Frame decode
   // ==========================================================
   // Link registers are static here: the frame has ended and the
   // clear is only issued the cycle after.
   always_comb begin
      csRise     = c_r.cs2 & ~c_r.cs3;
      frameOk    = (lk_r.cnt == '0);
      execCmd    = csRise & frameOk;
      cmd        = digipot_pkg::cmd_e'({lk_r.sr[CMD_HI], lk_r.sr[CMD_LO]});
      sel        = {lk_r.sr[SEL1], lk_r.sr[SEL0]};
      data       = lk_r.sr[`DP_DATA_W-1:0];
      presetFire = c_r.cs2 & (c_r.rsCnt == RS_CYC);
      psRise     = c_r.ps2 & ~c_r.ps3 & c_r.cs2 & (c_r.psCnt == PS_CYC);
   end

   // ==========================================================
   // Core side
   // ==========================================================
   always_comb begin
      c_nxt     = c_r;
      c_nxt.cs1 = csN;
      c_nxt.cs2 = c_r.cs1;
      c_nxt.cs3 = c_r.cs2;
      c_nxt.rs1 = wiperPresetN;
      c_nxt.rs2 = c_r.rs1;
      c_nxt.ps1 = powerSavePinN;
      c_nxt.ps2 = c_r.ps1;
      c_nxt.ps3 = c_r.ps2;
      c_nxt.clr = csRise;

      // Low-time timers count only with chip select high
      if (c_r.cs2 && !c_r.rs2) begin
         if (c_r.rsCnt != RS_CYC) begin
            c_nxt.rsCnt = `DP_TIMER_W'(c_r.rsCnt + 1'b1);
         end
      end else begin
         c_nxt.rsCnt = '0;
      end
      if (c_r.cs2 && !c_r.ps2) begin
         if (c_r.psCnt != PS_CYC) begin
            c_nxt.psCnt = `DP_TIMER_W'(c_r.psCnt + 1'b1);
         end
      end else begin
         c_nxt.psCnt = '0;
      end

      if (csRise) begin
         c_nxt.armed = 1'b1;
      end

      if (execCmd) begin
         case (cmd)
            digipot_pkg::CMD_WRITE: begin
               if (sel[0]) begin
                  c_nxt.wiper0 = data;
               end
               if (sel[1]) begin
                  c_nxt.wiper1 = data;
               end
               if (c_r.ps2) begin
                  c_nxt.swShdn = c_r.swShdn & ~sel;
               end
            end
            digipot_pkg::CMD_POWER_SAVE_PIN_N: begin
               c_nxt.swShdn = c_r.swShdn | sel;
            end
            default: begin
            end
         endcase
      end

      if (presetFire) begin
         c_nxt.wiper0 = `DP_MID_SCALE;
         c_nxt.wiper1 = `DP_MID_SCALE;
         if (c_r.armed && c_r.ps2) begin
            c_nxt.swShdn = 2'h0;
            c_nxt.armed  = 1'b0;
         end
      end

      if (psRise && c_r.armed) begin
         c_nxt.swShdn = 2'h0;
         c_nxt.armed  = 1'b0;
      end

      // Data registers never touched by power-save itself
      c_nxt.effShdn = c_nxt.swShdn | {2{~c_nxt.ps2}};
      c_nxt.standby = c_nxt.cs2;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         c_r         <= '0;
         c_r.cs1     <= 1'b1;
         c_r.cs2     <= 1'b1;
         c_r.cs3     <= 1'b1;
         c_r.rs1     <= 1'b1;
         c_r.rs2     <= 1'b1;
         c_r.clr     <= 1'b1;
         c_r.wiper0  <= `DP_MID_SCALE;
         c_r.wiper1  <= `DP_MID_SCALE;
         c_r.effShdn <= 2'h3;
         c_r.standby <= 1'b1;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign wiper0      = c_r.wiper0;
   assign wiper1      = c_r.wiper1;
   assign potShutdown = c_r.effShdn;
   assign standby     = c_r.standby;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_write_load: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && sel[0] && !presetFire
      |=> wiper0 == $past(data))
      else $error("Write did not load pot 0");

   a_write_keep: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && !sel[1] && !presetFire
      |=> $stable(wiper1))
      else $error("Unselected pot 1 changed on write");

   a_power_save_pin_n_enter: assert property (
      execCmd && cmd == digipot_pkg::CMD_POWER_SAVE_PIN_N && !presetFire && !psRise
      |=> c_r.swShdn == ($past(c_r.swShdn) | $past(sel)))
      else $error("Shutdown command did not set selected flags");

   a_abort_frame: assert property (
      csRise && !frameOk && !presetFire && !psRise
      |=> $stable(wiper0) && $stable(wiper1) && $stable(c_r.swShdn))
      else $error("Aborted frame changed state");

   a_write_wake: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && sel[0] && c_r.ps2
      |=> !c_r.swShdn[0] ##1 !potShutdown[0] || !c_r.ps2)
      else $error("Write with power-save high kept shutdown");

   a_write_asleep: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && !c_r.ps2
      |=> potShutdown == 2'h3)
      else $error("Write during power-save released shutdown");

   a_force_power_save_pin_n: assert property (
      !c_r.ps2 |-> potShutdown == 2'h3)
      else $error("Power-save low did not force shutdown");

   a_preset_mid: assert property (
      presetFire |=> wiper0 == `DP_MID_SCALE && wiper1 == `DP_MID_SCALE)
      else $error("Preset did not set mid-scale");

   a_psave_hold: assert property (
      !c_r.ps2 && !csRise && !presetFire |=> $stable(wiper0) && $stable(wiper1))
      else $error("Power-save altered data registers");

   a_frame_clear: assert property (
      csRise |-> ##2 (lk_r.sr == '0) && !spiDout)
      else $error("Frame end did not clear shift register and output");

   // Guards on the pot registers, the shutdown flags, standby and the clock count
   a_write_load1: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && sel[1] && !presetFire
      |=> wiper1 == $past(data))
      else $error("Write did not load pot 1");

   a_write_keep0: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && !sel[0] && !presetFire
      |=> $stable(wiper0))
      else $error("Unselected pot 0 changed on write");

   a_write_flag: assert property (
      execCmd && cmd == digipot_pkg::CMD_WRITE && !sel[0] && !presetFire && !psRise
      |=> c_r.swShdn[0] == $past(c_r.swShdn[0]))
      else $error("Write changed shutdown of unselected pot 0");

   a_nop_keep: assert property (
      execCmd && (cmd == digipot_pkg::CMD_NOP_LO || cmd == digipot_pkg::CMD_NOP_HI)
      && !presetFire && !psRise
      |=> $stable(wiper0) && $stable(wiper1) && $stable(c_r.swShdn))
      else $error("No-operation command changed state");

   a_power_save_pin_n_data: assert property (
      execCmd && cmd == digipot_pkg::CMD_POWER_SAVE_PIN_N && !presetFire
      |=> $stable(wiper0) && $stable(wiper1))
      else $error("Shutdown command altered data registers");

   a_power_save_pin_n_select: assert property (
      execCmd && cmd == digipot_pkg::CMD_POWER_SAVE_PIN_N && !sel[0] && !presetFire && !psRise
      |=> c_r.swShdn[0] == $past(c_r.swShdn[0]))
      else $error("Shutdown command touched unselected pot 0");

   a_preset_wake: assert property (
      presetFire && c_r.armed && c_r.ps2
      |=> c_r.swShdn == 2'h0)
      else $error("Armed preset did not release shutdown");

   a_psave_wake: assert property (
      psRise && c_r.armed
      |=> c_r.swShdn == 2'h0)
      else $error("Armed power-save release kept shutdown");

   a_preset_asleep: assert property (
      presetFire && !c_r.ps2 && !c_r.ps1
      |=> potShutdown == 2'h3)
      else $error("Preset during power-save released shutdown");

   a_standby_pin: assert property (
      $fell(c_r.cs1) |=> !standby)
      else $error("Frame start did not leave standby");

   a_count_clear: assert property (
      c_r.clr |-> lk_r.cnt == '0)
      else $error("Frame end did not clear the clock count");

   a_wiper_cause: assert property (
      $changed(wiper0) && !$past(execCmd)
      |-> $past(presetFire) && wiper0 == `DP_MID_SCALE)
      else $error("Pot 0 changed without command or preset");

   c_write:   cover property (execCmd && cmd == digipot_pkg::CMD_WRITE);
   c_power_save_pin_n:    cover property (execCmd && cmd == digipot_pkg::CMD_POWER_SAVE_PIN_N);
   c_preset:  cover property (presetFire && c_r.armed);
   c_psave:   cover property (psRise && c_r.armed);
   c_abort:   cover property (csRise && !frameOk);

endmodule

`default_nettype wire

/* File: src/digipot_params.svh */
// Timing counts, field positions and reset values of the potentiometer control block.
// Assumes the core clock runs at the rate given by DP_CLK_NS.
`ifndef DIGIPOT_PARAMS_SVH
`define DIGIPOT_PARAMS_SVH

`define DP_FRAME_BITS  16
`define DP_DATA_W      8
`define DP_CNT_W       4
`define DP_CMD_HI_POS  5
`define DP_CMD_LO_POS  4
`define DP_SEL1_POS    1
`define DP_SEL0_POS    0
`define DP_MID_SCALE   8'h80
`define DP_CLK_NS      5
`define DP_PRESET_NS   150
`define DP_PSAVE_NS    100
`define DP_PRESET_CYC  ((`DP_PRESET_NS + `DP_CLK_NS - 1) / `DP_CLK_NS)
`define DP_PSAVE_CYC   ((`DP_PSAVE_NS + `DP_CLK_NS - 1) / `DP_CLK_NS)
`define DP_TIMER_W     5

`endif

/* File: src/digipot_pkg.sv */
// Types of the potentiometer control block.
// Assumes digipot_params.svh is on the include path.
`include "digipot_params.svh"

package digipot_pkg;

   typedef enum logic [1:0] {
      CMD_NOP_LO = 2'h0,
      CMD_WRITE  = 2'h1,
      CMD_POWER_SAVE_PIN_N   = 2'h2,
      CMD_NOP_HI = 2'h3
   } cmd_e;

   // Link-side state, clocked by the serial clock
   typedef struct packed {
      logic [`DP_FRAME_BITS-1:0] sr;
      logic [`DP_CNT_W-1:0]      cnt;
   } link_s;

   // Core-side state, clocked by mclk
   typedef struct packed {
      logic                   cs1;
      logic                   cs2;
      logic                   cs3;
      logic                   rs1;
      logic                   rs2;
      logic                   ps1;
      logic                   ps2;
      logic                   ps3;
      logic [`DP_TIMER_W-1:0] rsCnt;
      logic [`DP_TIMER_W-1:0] psCnt;
      logic                   armed;
      logic                   clr;
      logic [1:0]             swShdn;
      logic [`DP_DATA_W-1:0]  wiper0;
      logic [`DP_DATA_W-1:0]  wiper1;
      logic [1:0]             effShdn;
      logic                   standby;
   } core_s;

endpackage

/* File: sim/spi_host_model.sv */
// Serial host model driving frames into the potentiometer block.
// Assumes mode 0,0: a 48 ns link clock that idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output var  logic spiClk,
   output var  logic csN,
   output var  logic spiDin,
   input  wire logic spiDout
);
   initial begin
      spiClk = 1'b0;
      csN    = 1'b1;
      spiDin = 1'b0;
   end
   // ======================================
   // Frame of n clocks, MSB first; q collects spiDout at each rising edge
   task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
      q = '0;
      csN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spiDin = d[i];
         #24 spiClk = 1'b1;
         q = {q[30:0], spiDout};
         #24 spiClk = 1'b0;
      end
      #24 csN = 1'b1;
      spiDin = ~spiDin;
   endtask
endmodule
`default_nettype wire

/* File: sim/test_digipot_spi_shutdown_reset_ctrl.sv */
// Self-checking bench of the potentiometer control block.
// Assumes digipot_params.svh on the include path and spi_host_model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "digipot_params.svh"
module test_digipot_spi_shutdown_reset_ctrl;
   logic                  mclk;
   logic                  rst;
   logic                  wiperPresetN;
   logic                  powerSavePinN;
   wire logic             spiClk;
   wire logic             csN;
   wire logic             spiDin;
   wire logic             spiDout;
   logic [`DP_DATA_W-1:0] wiper0;
   logic [`DP_DATA_W-1:0] wiper1;
   logic [1:0]            potShutdown;
   logic                  standby;
   logic [31:0]           q;
   int                    n_fail;
   int                    n_tests;

   digipot_spi_shutdown_reset_ctrl digipot_spi_shutdown_reset_ctrl_i (
      .mclk(mclk), .rst(rst), .spiClk(spiClk), .csN(csN), .spiDin(spiDin),
      .spiDout(spiDout), .wiperPresetN(wiperPresetN), .powerSavePinN(powerSavePinN),
      .wiper0(wiper0), .wiper1(wiper1), .potShutdown(potShutdown), .standby(standby));
   spi_host_model spi_host_model_i (
      .spiClk(spiClk), .csN(csN), .spiDin(spiDin), .spiDout(spiDout));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // ======================================
   // Helpers
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
         n_fail++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic frame(input int n, input logic [31:0] d);
      spi_host_model_i.xfer(n, d, q);
      cyc(10);
   endtask
   task automatic pins(input logic ps, input logic pr);
      @(posedge mclk);
      powerSavePinN <= ps;
      wiperPresetN  <= pr;
   endtask
   // Bounded wait for the shutdown outputs to reach e
   task automatic waitShut(input logic [1:0] e);
      int i;
      for (i = 0; i < 60 && potShutdown !== e; i++) cyc(1);
      chk({14'h0, potShutdown}, {14'h0, e});
      if (potShutdown !== e) begin
         results();
      end
   endtask
   // ======================================
   // Scenarios
   task automatic t_reset();
      chk({14'h0, potShutdown}, 16'h0003);
      chk(wiper0, `DP_MID_SCALE);
      chk(wiper1, `DP_MID_SCALE);
      chk(spiDout, 1'b0);
      chk(standby, 1'b1);
      pins(1'b1, 1'b1);
      waitShut(2'b00);
      $display("reset test done");
   endtask
   task automatic t_write();
      logic [15:0] d [5] = '{16'h115A, 16'h12C3, 16'h03FF, 16'h33EE, 16'h1301};
      logic [7:0] e0 [5] = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h01};
      logic [7:0] e1 [5] = '{8'h80, 8'hC3, 8'hC3, 8'hC3, 8'h01};
      for (int i = 0; i < 5; i++) begin
         frame(16, {16'h0, d[i]});
         chk(wiper0, e0[i]);
         chk(wiper1, e1[i]);
      end
      $display("write test done");
   endtask
   task automatic t_power_save_pin_n();
      frame(16, 32'h22AB);
      chk({14'h0, potShutdown}, 16'h0002);
      frame(15, 32'h1255);
      chk({14'h0, potShutdown}, 16'h0002);
      chk(wiper1, 8'h01);
      frame(16, 32'h1266);
      waitShut(2'b00);
      chk(wiper1, 8'h66);
      $display("shutdown test done");
   endtask
   task automatic t_daisy();
      frame(32, {16'h1233, 16'h0000});
      chk(q[31:16], 16'h0000);
      chk(q[15:0], 16'h1233);
      chk(wiper1, 8'h66);
      chk(spiDout, 1'b0);
      $display("daisy test done");
   endtask
   task automatic t_psave();
      frame(16, 32'h2300);
      pins(1'b0, 1'b1);
      cyc(30);
      chk({14'h0, potShutdown}, 16'h0003);
      frame(16, 32'h1377);
      chk(wiper0, 8'h77);
      chk(wiper1, 8'h77);
      chk({14'h0, potShutdown}, 16'h0003);
      cyc(25);
      pins(1'b1, 1'b1);
      waitShut(2'b00);
      chk(wiper0, 8'h77);
      $display("power-save test done");
   endtask
   task automatic t_preset();
      frame(16, 32'h2100);
      chk({14'h0, potShutdown}, 16'h0001);
      pins(1'b1, 1'b0);
      cyc(45);
      chk(wiper0, `DP_MID_SCALE);
      chk(wiper1, `DP_MID_SCALE);
      waitShut(2'b00);
      pins(1'b1, 1'b1);
      frame(16, 32'h1311);
      pins(1'b0, 1'b1);
      cyc(30);
      pins(1'b0, 1'b0);
      cyc(45);
      pins(1'b0, 1'b1);
      cyc(5);
      chk(wiper0, `DP_MID_SCALE);
      chk({14'h0, potShutdown}, 16'h0003);
      pins(1'b1, 1'b1);
      waitShut(2'b00);
      $display("preset test done");
   endtask

   initial begin
      n_fail = 0;
      n_tests = 0;
      rst = 1'b1;
      wiperPresetN = 1'b1;
      powerSavePinN = 1'b0;
      cyc(16);
      rst <= 1'b0;
      cyc(8);
      t_reset();
      t_write();
      t_power_save_pin_n();
      t_daisy();
      t_psave();
      t_preset();
      results();
   end
endmodule
`default_nettype wire
